/* hdl/serial_pin_port.sv */
/*
 Three-pin general-purpose port shared with the serial interface's
 clock, receive and transmit pins, with an APB register slave.
 Assumes pins and standby requests arrive asynchronously; the serial
 interface's own clock and transmit data are on CLK_SYS.
*/
`timescale 1ns/1ps
`include "serial_port_params.svh"

module serial_pin_port (
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [17:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output wire logic [31:0] PRDATA,
    output wire logic        PREADY,
    output wire logic        PSLVERR,
    input  wire logic [2:0]  PIN_IN,
    output wire logic [2:0]  PIN_OUT,
    output wire logic [2:0]  PIN_OE_N,
    input  wire logic        HW_STANDBY,
    input  wire logic        SW_STANDBY,
    input  wire logic        SER_CLK_OUT,
    input  wire logic        SER_TXD,
    output wire logic        SER_CLK_IN,
    output wire logic        SER_RXD,
    output wire logic        SER_RESET
);

    // Every field is listed so a new field cannot slip in without a reset value
    localparam serial_port_pkg::port_state_t RESET_STATE = '{
        phase      : serial_port_pkg::PH_IDLE,
        prdata     : 32'h00000000,
        pready     : 1'b0,
        pslverr    : 1'b0,
        dir        : 3'(`DIR_RESET),
        data       : 3'(`DATA_RESET),
        select     : 5'h00,
        pin_meta   : 3'h0,
        pin_sync   : 3'h0,
        stby_meta  : 2'h0,
        stby_sync  : 2'h0,
        sw_prev    : 1'b0,
        pin_out    : 3'h0,
        pin_oe_n   : 3'h7,
        ser_clk_in : 1'b0,
        ser_rxd    : 1'b0,
        ser_reset  : 1'b0
    };

    logic                         rst_meta;
    logic                         rst_sync;
    serial_port_pkg::port_state_t s;
    serial_port_pkg::port_state_t next_s;

    logic                         hw_stby;
    logic                         sw_stby;
    logic                         sw_entry;
    logic                         setup;
    logic                         access;
    logic                         write_done;
    logic                         dir_write;
    logic                         data_write;
    logic                         select_write;

    logic                         hit_dir;
    logic                         hit_data;
    logic                         hit_select;
    logic                         addr_hit;
    logic [31:0]                  read_value;

    logic                         clk_input;
    logic                         clk_output;
    logic                         rx_input;
    logic                         tx_output;
    logic [2:0]                   gpio_oe_n;
    logic [2:0]                   pin_level;

    function automatic logic [17:0] byte_addr(
        input logic [15:0] index
    );
        byte_addr = {index, 2'b00};
    endfunction

    // One register decode shared by the read path and the write path
    function automatic logic reg_hit(
        input logic [17:0] addr,
        input logic [15:0] index
    );
        reg_hit = (addr == byte_addr(index));
    endfunction

    // Output pins show the stored bit, input pins the live level
    function automatic logic [2:0] port_read(
        input logic [2:0] dir,
        input logic [2:0] data,
        input logic [2:0] pin
    );
        port_read = (dir & data) | (~dir & pin);
    endfunction

    // Only the three port bits exist; the reserved bits are not stored
    function automatic logic [2:0] reg_write(
        input logic [2:0]  old,
        input logic [31:0] wdata,
        input logic        enable
    );
        reg_write = enable ? wdata[2:0] : old;
    endfunction

    // A serial input is low in reset and idles high after it while its pin is not handed over
    function automatic logic serial_input(
        input logic enable,
        input logic level
    );
        serial_input = enable ? level : 1'b1;
    endfunction

    // Clock pin is a serial input whenever clock-enable-high is set
    function automatic logic clk_pin_input(input logic [4:0] select);
        clk_pin_input = select[`SEL_CKE_HIGH];
    endfunction

    // Clock pin drives the serial clock in sync mode or with the low enable, unless clock-enable-high is set
    function automatic logic clk_pin_output(input logic [4:0] select);
        clk_pin_output = ~select[`SEL_CKE_HIGH]
                         & (select[`SEL_SYNC] | select[`SEL_CKE_LOW]);
    endfunction

    // Release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Both standby requests come from pins and pass the synchronisers first
    assign hw_stby  = s.stby_sync[1];
    assign sw_stby  = s.stby_sync[0];
    assign sw_entry = sw_stby & ~s.sw_prev;

    assign setup        = PSEL & ~PENABLE;
    assign access       = (s.phase == serial_port_pkg::PH_ACCESS) & PSEL & PENABLE;
    // The write lands on the edge where the master sees PREADY high
    assign write_done   = access & PWRITE & s.pready & ~s.pslverr & PSTRB[0];
    assign dir_write    = write_done & hit_dir;
    assign data_write   = write_done & hit_data;
    assign select_write = write_done & hit_select;

    // Unmapped addresses answer with an error and change nothing
    assign hit_dir    = reg_hit(PADDR, `DIR_INDEX);
    assign hit_data   = reg_hit(PADDR, `DATA_INDEX);
    assign hit_select = reg_hit(PADDR, `SELECT_INDEX);
    assign addr_hit   = hit_dir | hit_data | hit_select;

    // Serial ownership of each pin, from the select register
    assign clk_input  = clk_pin_input(s.select);
    assign clk_output = clk_pin_output(s.select);
    assign rx_input   = s.select[`SEL_RX_EN];
    assign tx_output  = s.select[`SEL_TX_EN];
    assign gpio_oe_n  = ~s.dir; // see [RL1]
    assign pin_level  = s.pin_sync;

    // Read data is captured in the setup cycle and held in prdata
    always_comb begin
        read_value = 32'h00000000;
        case ({hit_select, hit_data, hit_dir})
            3'b001: begin
                read_value = `DIR_READ_VALUE; // see [RL2]
            end
            3'b010: begin
                read_value = {24'h000000, `RESERVED_ONES, // see [RL6]
                              port_read(s.dir, s.data, pin_level)}; // see [RL7]
            end
            3'b100: begin
                read_value = {27'h0000000, s.select};
            end
            default: begin
                read_value = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        next_s = s;

        // Two-stage synchronisers for pins and standby requests
        next_s.pin_meta  = PIN_IN;
        next_s.pin_sync  = s.pin_meta;

        next_s.stby_meta = {HW_STANDBY, SW_STANDBY};
        next_s.stby_sync = s.stby_meta;
        next_s.sw_prev   = sw_stby;

        // Zero-wait slave: data is prepared in setup, ready in access
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        case (s.phase)
            serial_port_pkg::PH_IDLE: begin
                if (setup) begin
                    next_s.phase   = serial_port_pkg::PH_ACCESS;
                    next_s.pready  = 1'b1;
                    next_s.pslverr = ~addr_hit;
                    // A write returns no data, so prdata is cleared
                    if (PWRITE) begin
                        next_s.prdata = 32'h00000000;
                    end else begin
                        next_s.prdata = read_value;
                    end
                end
            end
            serial_port_pkg::PH_ACCESS: begin
                next_s.phase = serial_port_pkg::PH_IDLE;
            end
            default: begin
                next_s.phase = serial_port_pkg::PH_IDLE;
            end
        endcase

        next_s.dir  = reg_write(s.dir, PWDATA, dir_write); // see [RL1]
        next_s.data = reg_write(s.data, PWDATA, data_write); // see [RL6]
        if (select_write) begin
            next_s.select = PWDATA[4:0];
        end

        // Software standby entry keeps port registers, frees serial pins
        next_s.ser_reset = sw_entry; // see [RL5]
        if (sw_entry) begin
            next_s.select = 5'h00; // see [RL5] [RL4]
        end

        // Hardware standby comes last so it wins over a write in the same cycle
        if (hw_stby) begin
            next_s.dir    = 3'(`DIR_RESET); // see [RL3]
            next_s.data   = 3'(`DATA_RESET); // see [RL8]
            next_s.select = 5'h00;
        end

        // Pin function; no operating mode term enters here, see [RL9]
        // Clock pin: serial input wins over serial output, output over port use
        if (clk_input) begin
            next_s.pin_oe_n[`PIN_CLK] = 1'b1; // see [RL10]
            next_s.pin_out[`PIN_CLK]  = s.data[`PIN_CLK];
        end else if (clk_output) begin
            next_s.pin_oe_n[`PIN_CLK] = 1'b0; // see [RL10]
            next_s.pin_out[`PIN_CLK]  = SER_CLK_OUT;
        end else begin
            next_s.pin_oe_n[`PIN_CLK] = gpio_oe_n[`PIN_CLK]; // see [RL11]
            next_s.pin_out[`PIN_CLK]  = s.data[`PIN_CLK];
        end

        // Receive pin
        if (rx_input) begin
            next_s.pin_oe_n[`PIN_RXD] = 1'b1; // see [RL12]
        end else begin
            next_s.pin_oe_n[`PIN_RXD] = gpio_oe_n[`PIN_RXD]; // see [RL12]
        end
        next_s.pin_out[`PIN_RXD] = s.data[`PIN_RXD];

        // Transmit pin
        if (tx_output) begin
            next_s.pin_oe_n[`PIN_TXD] = 1'b0; // see [RL13]
            next_s.pin_out[`PIN_TXD]  = SER_TXD;
        end else begin
            next_s.pin_oe_n[`PIN_TXD] = gpio_oe_n[`PIN_TXD]; // see [RL13]
            next_s.pin_out[`PIN_TXD]  = s.data[`PIN_TXD];
        end

        next_s.ser_clk_in = serial_input(clk_input, pin_level[`PIN_CLK]);
        next_s.ser_rxd    = serial_input(rx_input, pin_level[`PIN_RXD]);
    end

    // Port state and bus answer registers
    always_ff @(posedge CLK_SYS or negedge rst_sync) begin
        if (!rst_sync) begin
            s <= RESET_STATE; // see [RL3] [RL8]
        end else begin
            s <= next_s;
        end
    end

    // Top-level outputs come straight from the state flip-flops
    assign PRDATA     = s.prdata;
    assign PREADY     = s.pready;
    assign PSLVERR    = s.pslverr;

    assign PIN_OUT    = s.pin_out;
    assign PIN_OE_N   = s.pin_oe_n;

    assign SER_CLK_IN = s.ser_clk_in;
    assign SER_RXD    = s.ser_rxd;
    assign SER_RESET  = s.ser_reset;

endmodule // serial_pin_port

/* hdl/serial_port_params.svh */
/*
 Constants for the three-pin general-purpose port whose pins are shared
 with the on-chip serial interface. Assumes a 50 MHz system clock and
 an APB slave with 32-bit data, one aligned word per register.
*/
// Notes on behaviour
// [RL1] A pin drives when its direction bit is 1 and is an input when the bit is 0.
// [RL2] The direction register is write-only and its bits 7 to 3 always read as 1.
// [RL3] Reset and hardware standby load the direction register with F8, all pins inputs.
// [RL4] Software standby keeps the direction register, so output pins keep driving.
// [RL5] Entering software standby resets the serial interface and returns its pins to the port.
// [RL6] The data register holds pin data in bits 2 to 0; bits 7 to 3 ignore writes, read 1.
// [RL7] A port read gives stored data for output pins and the pin level for input pins.
// [RL8] The data register is F8 after reset and hardware standby and kept in software standby.
// [RL9] Pin function selection does not depend on the chip operating mode.
// [RL10] Clock pin is serial clock input if clock-enable-high is 1, else output if sync or low.
// [RL11] With both clock enables and the sync bit at 0 the clock pin is a port pin.
// [RL12] Receive pin is the serial receive input when receiver enable is 1, else a port pin.
// [RL13] Transmit pin is the serial transmit output when transmitter enable is 1, else a port pin.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define DIR_INDEX      16'hFFB8
`define DATA_INDEX     16'hFFBA
`define SELECT_INDEX   16'hFFBC

`define DIR_RESET      8'hF8
`define DATA_RESET     8'hF8
`define RESERVED_ONES  5'h1F
`define DIR_READ_VALUE 32'h000000FF

// Pin positions within the port
`define PIN_TXD        0
`define PIN_RXD        1
`define PIN_CLK        2

// Fields of the serial pin select register
`define SEL_CKE_LOW    0
`define SEL_CKE_HIGH   1
`define SEL_SYNC       2
`define SEL_RX_EN      3
`define SEL_TX_EN      4

`endif

/* hdl/serial_port_pkg.sv */
/*
 Types for the three-pin port: bus phase enumeration and the packed
 state of the port module. Assumes the constants header is included
 by the design file that uses it.
*/
package serial_port_pkg;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'b01,
        PH_ACCESS = 2'b10
    } bus_phase_t;

    typedef struct packed {
        bus_phase_t  phase;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  dir;
        logic [2:0]  data;
        logic [4:0]  select;
        logic [2:0]  pin_meta;
        logic [2:0]  pin_sync;
        logic [1:0]  stby_meta;
        logic [1:0]  stby_sync;
        logic        sw_prev;
        logic [2:0]  pin_out;
        logic [2:0]  pin_oe_n;
        logic        ser_clk_in;
        logic        ser_rxd;
        logic        ser_reset;
    } port_state_t;

endpackage

/* verification/serial_pin_port_chk.sv */
/* Checker on the ports of serial_pin_port.
 Assumes no bus setup before the reset release has run out. */
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_pin_port_chk (
    input wire logic        CLK_SYS,
    input wire logic        RESETN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [17:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [2:0]  PIN_OE_N,
    input wire logic        HW_STANDBY,
    input wire logic        SW_STANDBY,
    input wire logic        SER_RESET
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    localparam logic [17:0] A_DIR = {`DIR_INDEX, 2'b00};
    localparam logic [17:0] A_DAT = {`DATA_INDEX, 2'b00};
    localparam logic [17:0] A_SEL = {`SELECT_INDEX, 2'b00};
    wire logic rd = PREADY && !PWRITE;
    wire logic hit = PADDR == A_DIR || PADDR == A_DAT || PADDR == A_SEL;
    AST_ANSWER: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready");
    AST_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
    AST_ERR: assert property (PREADY |-> PSLVERR == !hit) else $error("bad slverr");
    AST_DIR_RD: assert property (rd && PADDR == A_DIR |-> PRDATA == `DIR_READ_VALUE)
        else $error("dir read");
    AST_DAT_RD: assert property (rd && PADDR == A_DAT |-> PRDATA[31:3] == 29'h1F)
        else $error("data read");
    AST_SW: assert property ($rose(SW_STANDBY) |-> ##[1:5] SER_RESET)
        else $error("no serial reset");
    AST_SW_PULSE: assert property (SER_RESET |=> !SER_RESET) else $error("long reset");
    AST_HW: assert property (HW_STANDBY [*6] |-> PIN_OE_N == 3'h7)
        else $error("hw standby drive");
    cover property (rd && PADDR == A_DAT);
    cover property (PSLVERR);
    cover property (SER_RESET);
endmodule // serial_pin_port_chk
bind serial_pin_port serial_pin_port_chk i_serial_pin_port_chk (.CLK_SYS, .RESETN, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .PIN_OE_N, .HW_STANDBY,
    .SW_STANDBY, .SER_RESET);

/* verification/board_pins.sv */
/* Board side of the three port pins.
 Assumes outside parts always hold a level, so no pin floats. */
`timescale 1ns/1ps
module board_pins (
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe_n,
    input  wire logic [2:0] ext,
    output wire logic [2:0] pin_in
);
    // Port drive wins, so a read of an output pin cannot hide a port fault
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
endmodule // board_pins

/* verification/tb.sv */
/* Bench for serial_pin_port: APB tasks and one task per scenario.
 Assumes board_pins for the pins and the bound checker. */
`timescale 1ns/1ps
`include "serial_port_params.svh"
module tb;
    localparam logic [17:0] A_DIR = {`DIR_INDEX, 2'b00};
    localparam logic [17:0] A_DAT = {`DATA_INDEX, 2'b00};
    localparam logic [17:0] A_SEL = {`SELECT_INDEX, 2'b00};
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        hw = 1'b0, sw = 1'b0, sclk = 1'b0, txd = 1'b1;
    logic        pready, pslverr, sclk_in, srxd, sres, err;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [2:0]  ext = 3'h0, pin_in, pin_out, pin_oe_n;
    int          n_fail = 0, checks = 0, cyc = 0;
    always #10 clk = ~clk;
    serial_pin_port i_serial_pin_port (.CLK_SYS(clk), .RESETN(rstn), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .HW_STANDBY(hw), .SW_STANDBY(sw),
        .SER_CLK_OUT(sclk), .SER_TXD(txd), .SER_CLK_IN(sclk_in), .SER_RXD(srxd),
        .SER_RESET(sres));
    board_pins i_board_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext(ext),
        .pin_in(pin_in));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // An idle edge first, so psel is never assigned twice in one step
    task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_reset;
        xfer(1'b0, A_DAT, 8'h0);
        chk(rdat, 32'hF8);
        xfer(1'b0, A_DIR, 8'h0);
        chk(rdat, `DIR_READ_VALUE);
        chk(32'(pin_oe_n), 32'h7);
        xfer(1'b0, 18'h4, 8'h0);
        chk(32'(err), 32'h1);
        $display("reset test done");
    endtask
    task automatic t_gpio;
        ext <= 3'h7;
        xfer(1'b1, A_DIR, 8'h05);
        xfer(1'b1, A_DAT, 8'h03);
        repeat (3) @(posedge clk);
        chk(32'(pin_oe_n), 32'h2);
        chk(32'(pin_out & 3'h5), 32'h1);
        xfer(1'b0, A_DAT, 8'h0);
        chk(rdat, 32'hFB);
        $display("port test done");
    endtask
    task automatic t_mux;
        ext <= 3'h0;
        sclk <= 1'b1;
        xfer(1'b1, A_SEL, 8'h1A);
        repeat (3) @(posedge clk);
        chk(32'(pin_oe_n), 32'h6);
        chk(32'({pin_out[0], sclk_in, srxd}), 32'h4);
        xfer(1'b0, A_DAT, 8'h0);
        chk(rdat, 32'hF9);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, A_SEL, i == 0 ? 8'h04 : i == 1 ? 8'h01 : 8'h00);
            repeat (3) @(posedge clk);
            chk(32'({pin_oe_n[2], pin_out[2]}), 32'(i < 2));
        end
        $display("mux test done");
    endtask
    task automatic t_stby;
        txd <= 1'b0;
        xfer(1'b1, A_SEL, 8'h10);
        repeat (3) @(posedge clk);
        chk(32'(pin_out[0]), 32'h0);
        sw <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(pin_oe_n), 32'h2);
        chk(32'(pin_out[0]), 32'h1);
        sw <= 1'b0;
        hw <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'(pin_oe_n), 32'h7);
        hw <= 1'b0;
        repeat (3) @(posedge clk);
        xfer(1'b1, A_DIR, 8'h07);
        xfer(1'b0, A_DAT, 8'h0);
        chk(rdat, 32'hF8);
        $display("standby test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_gpio;
        t_mux;
        t_stby;
        finish_test;
    end
endmodule // tb
